// *** core/pcrs_seq.sv ***
`timescale 1ns/10ps
module pcrs_seq
	import pcrs_pkg::*;
(
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic fundamental_reset_port_a_n_in,
	input wire logic fundamental_reset_port_b_n_in,
	input wire logic platform_manager_por_n_in,
	input wire logic [PCRS_PORTS-1:0] port_enable_in,
	input wire logic [PCRS_PORTS-1:0] link_up_in,
	input wire logic [1:0] link_speed_in,
	input wire logic [2:0] link_width_in,
	input wire logic [1:0] ref_clk_sel_in,
	output logic [PCRS_PORTS-1:0] ctrl_reset_out,
	output logic [PCRS_PORTS-1:0] train_start_out,
	output logic [PCRS_PORTS-1:0] training_out,
	output logic [PCRS_PORTS-1:0] fabric_reset_out,
	output logic [1:0] fabric_clk_sel_out,
	output logic ref_clk_ok_out
);
	typedef enum logic [1:0] {
		PCRS_ST_RESET,
		PCRS_ST_TRAIN,
		PCRS_ST_UP
	} pcrs_state_e;

	logic [PCRS_PORTS-1:0] perst_n_raw;
	logic [PCRS_PORTS-1:0] perst_n;
	logic [PCRS_PORTS-1:0] link_up_sync;
	logic por_n;
	logic [1:0] fclk_sel;
	logic [1:0] next_fclk_sel;
	logic ref_ok;
	logic next_ref_ok;

	// Pins come from other domains: two flops each
	assign perst_n_raw = {fundamental_reset_port_b_n_in,
		fundamental_reset_port_a_n_in};

	pcrs_sync u_por_sync (
		.clk_in(clk_in),
		.reset_n_in(reset_n_in),
		.async_in(platform_manager_por_n_in),
		.sync_out(por_n)
	);

	// Clock select is a plain decode, registered
	always_comb begin
		logic [3:0] load;
		load = {2'h0, link_speed_in} + {1'h0, link_width_in};
		if (load >= PCRS_LOAD_HIGH) begin
			next_fclk_sel = PCRS_FCLK_250M;
		end else if (load >= PCRS_LOAD_MID) begin
			next_fclk_sel = PCRS_FCLK_125M;
		end else begin
			next_fclk_sel = PCRS_FCLK_62M5;
		end
		if (!reset_n_in) begin
			next_fclk_sel = PCRS_FCLK_62M5;
		end
	end

	always_ff @(posedge clk_in) begin
		fclk_sel <= next_fclk_sel;
	end

	// Only flags the select; the clock itself is the system's to supply
	always_comb begin
		next_ref_ok = (ref_clk_sel_in == PCRS_REF_100M) ||
			(ref_clk_sel_in == PCRS_REF_125M) ||
			(ref_clk_sel_in == PCRS_REF_250M);
		if (!reset_n_in) begin
			next_ref_ok = 1'b0;
		end
	end

	always_ff @(posedge clk_in) begin
		ref_ok <= next_ref_ok;
	end

	assign fabric_clk_sel_out = fclk_sel;
	assign ref_clk_ok_out = ref_ok;

	genvar gi;
	generate
		for (gi = 0; gi < PCRS_PORTS; gi++) begin : g_port
			pcrs_state_e state;
			pcrs_state_e next_state;
			logic [7:0] cnt;
			logic [7:0] next_cnt;
			logic start;
			logic next_start;
			logic frst;
			logic next_frst;
			logic released;
			logic retrain_due;

			// Registered copies of the state decode
			logic ctrl;
			logic next_ctrl;
			logic trn;
			logic next_trn;

			pcrs_sync u_perst_sync (
				.clk_in(clk_in),
				.reset_n_in(reset_n_in),
				.async_in(perst_n_raw[gi]),
				.sync_out(perst_n[gi])
			);

			pcrs_sync u_link_sync (
				.clk_in(clk_in),
				.reset_n_in(reset_n_in),
				.async_in(link_up_in[gi]),
				.sync_out(link_up_sync[gi])
			);

			// Both sources must be released, and the port enabled
			assign released = perst_n[gi] && por_n &&
				port_enable_in[gi];

			// Retrain timer expiry; the partner may never answer
			assign retrain_due = (cnt == PCRS_TRAIN_CYC - 8'h01);

			always_comb begin
				next_state = state;
				next_cnt = cnt;
				next_start = 1'b0;
				next_frst = 1'b1;
				case (state)
					PCRS_ST_RESET: begin
						// Link state is ignored until released
						next_cnt = 8'h00;
						if (released) begin
							next_state = PCRS_ST_TRAIN;
							next_start = 1'b1;
						end
					end

					PCRS_ST_TRAIN: begin
						// Retrain if link partner never answers
						if (link_up_sync[gi]) begin
							// User logic leaves reset with an active link
							next_state = PCRS_ST_UP;
							next_frst = 1'b0;
						end else if (retrain_due) begin
							next_cnt = 8'h00;
							next_start = 1'b1;
						end else begin
							next_cnt = cnt + 8'h01;
						end
					end

					PCRS_ST_UP: begin
						// A link drop takes user logic down at once
						next_frst = 1'b0;
						if (!link_up_sync[gi]) begin
							next_state = PCRS_ST_TRAIN;
							next_frst = 1'b1;
							next_cnt = 8'h00;
						end
					end

					default: begin
						next_state = PCRS_ST_RESET;
					end
				endcase
				// Any reset source drops us back hard
				if (!released) begin
					next_state = PCRS_ST_RESET;
					next_frst = 1'b1;
					next_start = 1'b0;
				end
				// Synchronous reset wins over every other source
				if (!reset_n_in) begin
					next_state = PCRS_ST_RESET;
					next_cnt = 8'h00;
					next_start = 1'b0;
					next_frst = 1'b1;
				end
				// Decode the next state so these outputs leave a flop
				next_ctrl = (next_state == PCRS_ST_RESET);
				next_trn = (next_state == PCRS_ST_TRAIN);
			end

			always_ff @(posedge clk_in) begin
				state <= next_state;
				cnt <= next_cnt;
				start <= next_start;
				frst <= next_frst;
				ctrl <= next_ctrl;
				trn <= next_trn;
			end

			assign ctrl_reset_out[gi] = ctrl;
			assign training_out[gi] = trn;
			assign train_start_out[gi] = start;
			assign fabric_reset_out[gi] = frst;
		end
	endgenerate
endmodule : pcrs_seq

// *** common/pcrs_pkg.sv ***
package pcrs_pkg;
	// Link width and speed codes
	localparam logic [2:0] PCRS_WIDTH_X1 = 3'h0;
	localparam logic [2:0] PCRS_WIDTH_X2 = 3'h1;
	localparam logic [2:0] PCRS_WIDTH_X4 = 3'h2;
	localparam logic [2:0] PCRS_WIDTH_X8 = 3'h3;
	localparam logic [2:0] PCRS_WIDTH_X16 = 3'h4;
	localparam logic [1:0] PCRS_GEN1 = 2'h0;
	localparam logic [1:0] PCRS_GEN2 = 2'h1;
	localparam logic [1:0] PCRS_GEN3 = 2'h2;
	localparam logic [1:0] PCRS_GEN4 = 2'h3;
	// Fabric clock rate select codes
	localparam logic [1:0] PCRS_FCLK_62M5 = 2'h0;
	localparam logic [1:0] PCRS_FCLK_125M = 2'h1;
	localparam logic [1:0] PCRS_FCLK_250M = 2'h2;
	// Reference clock codes
	localparam logic [1:0] PCRS_REF_100M = 2'h0;
	localparam logic [1:0] PCRS_REF_125M = 2'h1;
	localparam logic [1:0] PCRS_REF_250M = 2'h2;
	// Rate sum thresholds: gen index plus width index
	localparam logic [3:0] PCRS_LOAD_MID = 4'h4;
	localparam logic [3:0] PCRS_LOAD_HIGH = 4'h6;
	// Training time (ns) and cycle count at 25 MHz
	localparam int PCRS_CLK_PERIOD_NS = 40;
	localparam int PCRS_TRAIN_NS = 2000;
	localparam int PCRS_TRAIN_CYC_I =
		(PCRS_TRAIN_NS + PCRS_CLK_PERIOD_NS - 1) / PCRS_CLK_PERIOD_NS;
	localparam logic [7:0] PCRS_TRAIN_CYC = PCRS_TRAIN_CYC_I[7:0];
	localparam int PCRS_PORTS = 2;
endpackage : pcrs_pkg

// *** core/pcrs_sync.sv ***
`timescale 1ns/10ps
module pcrs_sync
	import pcrs_pkg::*;
(
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic async_in,
	output logic sync_out
);
	logic stage1;
	logic stage2;
	logic next_stage1;
	logic next_stage2;

	// Reset value low keeps resets asserted until proven released
	always_comb begin
		next_stage1 = async_in;
		next_stage2 = stage1;
		if (!reset_n_in) begin
			next_stage1 = 1'b0;
			next_stage2 = 1'b0;
		end
	end

	always_ff @(posedge clk_in) begin
		stage1 <= next_stage1;
		stage2 <= next_stage2;
	end

	assign sync_out = stage2;
endmodule : pcrs_sync

// *** bench/pcrs_seq_monitor.sv ***
`timescale 1ns/10ps
module pcrs_mon
	import pcrs_pkg::*;
(
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic fundamental_reset_port_a_n_in,
	input wire logic fundamental_reset_port_b_n_in,
	input wire logic platform_manager_por_n_in,
	input wire logic [1:0] port_enable_in,
	input wire logic [1:0] link_up_in,
	input wire logic [1:0] ref_clk_sel_in,
	input wire logic [1:0] ctrl_reset_out,
	input wire logic [1:0] train_start_out,
	input wire logic [1:0] training_out,
	input wire logic [1:0] fabric_reset_out,
	input wire logic ref_clk_ok_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!reset_n_in);
	wire pa = fundamental_reset_port_a_n_in & platform_manager_por_n_in;
	wire pb = fundamental_reset_port_b_n_in & platform_manager_por_n_in;
	// Three samples cover the two sync flops plus the state update
	sequence s_off_a; (!(pa & port_enable_in[0]))[*3]; endsequence
	sequence s_off_b; (!(pb & port_enable_in[1]))[*3]; endsequence
	a_hold_a: assert property (s_off_a |=> ctrl_reset_out[0])
		else $error("port a left reset early");
	a_hold_b: assert property (s_off_b |=> ctrl_reset_out[1])
		else $error("port b left reset early");
	a_train_go: assert property ($fell(ctrl_reset_out[0]) |->
		training_out[0] && train_start_out[0]) else $error("no training");
	a_pulse_one: assert property (train_start_out[0] |=>
		!train_start_out[0]) else $error("start pulse too long");
	a_down_reset: assert property ((!link_up_in[0])[*3] |=>
		fabric_reset_out[0]) else $error("fabric reset not on link down");
	a_up_release: assert property ($fell(fabric_reset_out[0]) |->
		$past(link_up_in[0], 3) && !ctrl_reset_out[0])
		else $error("fabric reset freed without link");
	a_ctrl_fabric: assert property (ctrl_reset_out[1] |->
		##[0:1] fabric_reset_out[1]) else $error("fabric reset missed");
	a_ref_legal: assert property ($past(reset_n_in) &&
		$past(reset_n_in, 2) |->
		ref_clk_ok_out == ($past(ref_clk_sel_in) != 2'h3))
		else $error("reference select flag wrong");
endmodule : pcrs_mon
bind pcrs_seq pcrs_mon u_mon (.*);

// *** bench/pcrs_fabric_model.sv ***
`timescale 1ns/10ps
module pcrs_user
	import pcrs_pkg::*;
(
	input wire logic clk_in,
	input wire logic fabric_reset_in,
	output logic [7:0] run_out
);
	// Reset taken synchronously, in the fabric clock domain
	always_ff @(posedge clk_in) begin
		run_out <= fabric_reset_in ? 8'h0 : run_out + 8'h1;
	end
endmodule : pcrs_user

// *** bench/pcrs_seq_bench.sv ***
`timescale 1ns/10ps
module pcrs_seq_bench
	import pcrs_pkg::*;
;
	logic clk_in = 1'b0;
	logic reset_n_in = 1'b0;
	logic pa = 1'b0, pb = 1'b0, por = 1'b0;
	logic [1:0] en = 2'h0, lu = 2'h0, spd = 2'h0, rsel = 2'h0;
	logic [2:0] wid = 3'h0;
	logic [1:0] ecs;
	logic eok;
	logic [7:0] run;
	wire logic [1:0] cr, ts, tr, fr, cs;
	wire logic ok;
	int err_total = 0, n_checks = 0, seed = 32'ha78f04ec, v, rh = 0;
	int st[2], s1[2], s2[2], l1[2], l2[2], cn[2], ru = 0;
	bit pe = 1'b1;
	always #20 clk_in = ~clk_in;
	pcrs_seq dut (.clk_in(clk_in), .reset_n_in(reset_n_in),
		.fundamental_reset_port_a_n_in(pa),
		.fundamental_reset_port_b_n_in(pb),
		.platform_manager_por_n_in(por), .port_enable_in(en),
		.link_up_in(lu), .link_speed_in(spd), .link_width_in(wid),
		.ref_clk_sel_in(rsel), .ctrl_reset_out(cr), .train_start_out(ts),
		.training_out(tr), .fabric_reset_out(fr),
		.fabric_clk_sel_out(cs), .ref_clk_ok_out(ok));
	pcrs_user far (.clk_in(clk_in), .fabric_reset_in(fr[0]), .run_out(run));
	task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH %s exp %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic close_out;
		if (err_total == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : close_out
	// Model: 0 reset, 1 training, 2 link up; two sync stages per pin
	always @(posedge clk_in) begin
		bit [1:0] r, ec, et, ef, es;
		int p;
		r = {pb & por, pa & por};
		rh = reset_n_in ? rh + 1 : 0;
		ecs = spd + wid >= PCRS_LOAD_HIGH ? PCRS_FCLK_250M :
			spd + wid >= PCRS_LOAD_MID ? PCRS_FCLK_125M : PCRS_FCLK_62M5;
		eok = rsel != 2'h3;
		ru = pe ? 0 : (ru + 1) % 256;
		for (int i = 0; i < 2; i++) begin
			p = st[i];
			// Enable is same-domain, so it is not delayed
			st[i] = !reset_n_in || !s2[i] || !en[i] ? 0 :
				p == 0 ? 1 : l2[i] ? 2 : 1;
			es[i] = st[i] == 1 &&
				(p == 0 || (p == 1 && cn[i] == PCRS_TRAIN_CYC_I - 1));
			cn[i] = p == 1 && st[i] == 1 &&
				cn[i] != PCRS_TRAIN_CYC_I - 1 ? cn[i] + 1 : 0;
			s2[i] = reset_n_in & s1[i];
			s1[i] = reset_n_in & r[i];
			l2[i] = reset_n_in & l1[i];
			l1[i] = reset_n_in & lu[i];
			ec[i] = st[i] == 0;
			et[i] = st[i] == 1;
			ef[i] = st[i] != 2;
		end
		pe = ef[0];
		#5;
		chk("ctrl_reset", {6'h0, cr}, {6'h0, ec});
		chk("train_start", {6'h0, ts}, {6'h0, es});
		chk("training", {6'h0, tr}, {6'h0, et});
		chk("fabric_reset", {6'h0, fr}, {6'h0, ef});
		if (rh > 1) begin
			chk("clk_sel", {6'h0, cs}, {6'h0, ecs});
			chk("ref_ok", {7'h0, ok}, {7'h0, eok});
			chk("user_run", run, ru[7:0]);
		end
	end
	initial begin
		#300000;
		err_total++;
		close_out();
	end
	initial begin
		repeat (4) @(posedge clk_in);
		#1 reset_n_in = 1'b1;
		for (int k = 0; k < 60; k++) begin
			v = $random(seed);
			{pa, pb, por, en} = v[1:0] == 2'h0 ? v[8:4] : 5'h1f;
			lu = v[10:9];
			spd = v[12:11];
			wid = v[15:13] % 3'h5;
			// Shared reference, mostly legal selects
			rsel = v[17:16];
			reset_n_in = v[29:24] != 6'h0;
			repeat (v[23:18] + 3) @(posedge clk_in);
			#1;
		end
		close_out();
	end
endmodule : pcrs_seq_bench
